/* File: shared/ccp_pkg.sv */
package ccp_pkg;
  // Register byte offsets
  localparam logic [7:0] CCP_CTRL_OFS = 8'h00;
  localparam logic [7:0] CCP_OPER_OFS = 8'h04;
  localparam logic [7:0] CCP_ALU_CMD_OFS = 8'h08;
  localparam logic [7:0] CCP_RESULT_OFS = 8'h0C;
  localparam logic [7:0] CCP_ADDR_CMD_OFS = 8'h10;
  localparam logic [7:0] CCP_ADDR_STAT_OFS = 8'h14;
  // Control register fields
  localparam int CCP_CARRY_BIT = 0;
  localparam int CCP_COM_BIT = 1;
  localparam int CCP_WC_BIT = 3;
  localparam int CCP_CC_LSB = 6;
  // Address command and status fields; operand B field
  localparam int CCP_KIND_LSB = 16;
  localparam int CCP_PAGE_LSB = 13;
  localparam int CCP_LATCH_LSB = 16;
  localparam int CCP_BUSY_BIT = 18;
  localparam int CCP_OPB_LSB = 8;
  // Address geometry
  localparam int CCP_LOW_W = 13;
  localparam int CCP_ADDR_W = 15;
  localparam int CCP_PAGE_BYTES = 8192;
  localparam logic [1:0] CCP_PAGE_RESET = 2'h0;
  localparam logic [1:0] CCP_PAGE_IRQ = 2'h0;
  // Timing
  localparam int CCP_INDIRECT_HOLD = 1;
  // Condition code values
  localparam logic [1:0] CCP_CC_GT = 2'h1;
  localparam logic [1:0] CCP_CC_EQ = 2'h0;
  localparam logic [1:0] CCP_CC_LT = 2'h2;
  // ALU operations
  localparam logic [2:0] CCP_OP_ADD = 3'h0;
  localparam logic [2:0] CCP_OP_SUB = 3'h1;
  localparam logic [2:0] CCP_OP_CMP = 3'h2;
  localparam logic [2:0] CCP_OP_ROL = 3'h3;
  localparam logic [2:0] CCP_OP_ROR = 3'h4;
  // Memory access kinds
  localparam logic [2:0] CCP_ACC_FETCH = 3'h0;
  localparam logic [2:0] CCP_ACC_DIRECT = 3'h1;
  localparam logic [2:0] CCP_ACC_INDIRECT = 3'h2;
  localparam logic [2:0] CCP_ACC_BRANCH = 3'h3;
  localparam logic [2:0] CCP_ACC_IRQ = 3'h4;

  typedef enum logic [0:0] {CCP_ADR_IDLE, CCP_ADR_HOLD} ccp_adr_e;
endpackage

/* File: shared/ccp_alu_if.sv */
`timescale 1ns/1ps
interface ccp_alu_if;
  logic [2:0] op;
  logic [7:0] a;
  logic [7:0] b;
  logic carry_in;
  logic wc;
  logic compare_mode_bit;
  logic [7:0] result;
  logic carry_out;
  logic [1:0] cc;
  logic valid_op;

  modport core (output op, output a, output b, output carry_in, output wc, output compare_mode_bit,
    input result, input carry_out, input cc, input valid_op);
  modport alu (input op, input a, input b, input carry_in, input wc, input compare_mode_bit,
    output result, output carry_out, output cc, output valid_op);
endinterface

/* File: design/ccp_alu.sv */
`timescale 1ns/1ps
module ccp_alu
  import ccp_pkg::*;
(
  ccp_alu_if.alu bus
);
  logic [8:0] wide;
  logic cin;
  logic gt;
  logic eq;

  always_comb
  begin
    wide = 9'h000;
    cin = 1'b0;
    gt = 1'b0;
    eq = (bus.a == bus.b);
    bus.result = bus.a;
    bus.carry_out = bus.carry_in;
    bus.valid_op = 1'b1;
    if (bus.compare_mode_bit)
      gt = (bus.a > bus.b);
    else
      gt = ($signed(bus.a) > $signed(bus.b));
    case (bus.op)
      CCP_OP_ADD:
      begin
        cin = bus.wc & bus.carry_in;
        wide = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin};
        bus.result = wide[7:0];
        bus.carry_out = wide[8];
      end
      CCP_OP_SUB:
      begin
        // Zero carry means borrow, so the extra unit is the inverted flag
        cin = bus.wc & ~bus.carry_in;
        wide = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, cin};
        bus.result = wide[7:0];
        bus.carry_out = ~wide[8];
      end
      CCP_OP_ROL:
      begin
        if (bus.wc)
        begin
          bus.result = {bus.a[6:0], bus.carry_in};
          bus.carry_out = bus.a[7];
        end
        else
          bus.result = {bus.a[6:0], bus.a[7]};
      end
      CCP_OP_ROR:
      begin
        if (bus.wc)
        begin
          bus.result = {bus.carry_in, bus.a[7:1]};
          bus.carry_out = bus.a[0];
        end
        else
          bus.result = {bus.a[0], bus.a[7:1]};
      end
      CCP_OP_CMP: bus.result = bus.a;
      default: bus.valid_op = 1'b0;
    endcase
    // Loaded value sets the code from its sign; compare sets it by relation
    if (bus.op == CCP_OP_CMP)
      bus.cc = gt ? CCP_CC_GT : (eq ? CCP_CC_EQ : CCP_CC_LT);
    else if (bus.result == 8'h00)
      bus.cc = CCP_CC_EQ;
    else
      bus.cc = bus.result[7] ? CCP_CC_LT : CCP_CC_GT;
  end
endmodule

/* File: design/ccp_core.sv */
`timescale 1ns/1ps
module ccp_core
  import ccp_pkg::*;
#(
  parameter int HOLD_CYCLES = CCP_INDIRECT_HOLD
)
(
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Memory address lines
  output logic [12:0] O_LOW_ADDRESS_LINES,
  output logic O_PAGE_ADDRESS_LINE_LOW,
  output logic O_PAGE_ADDRESS_LINE_HIGH,
  output logic O_ADDR_STROBE,
  // Status view
  output logic O_CARRY,
  output logic [1:0] O_CONDITION_CODE
);
  localparam int HOLD_W = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES) : 1;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);

  typedef struct packed {
    ccp_adr_e st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic carry;
    logic compare_mode_bit;
    logic wc;
    logic [1:0] cc;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [7:0] result;
    logic [1:0] page;
    logic [1:0] page_out;
    logic [12:0] low_addr;
    logic strobe;
    logic [HOLD_W-1:0] hold;
  } ccp_state_s;

  localparam ccp_state_s RESET_STATE = '{
    st: CCP_ADR_IDLE,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    carry: 1'b0,
    compare_mode_bit: 1'b0,
    wc: 1'b0,
    cc: 2'h0,
    op_a: 8'h00,
    op_b: 8'h00,
    result: 8'h00,
    page: CCP_PAGE_RESET,
    page_out: CCP_PAGE_RESET,
    low_addr: 13'h0000,
    strobe: 1'b0,
    hold: '0
  };

  ccp_state_s state_reg;
  ccp_state_s state_next;

  ccp_alu_if alu_bus ();

  ccp_alu u_alu (
    .bus (alu_bus)
  );

  // ALU sees stored operands; the operation comes with the command write
  assign alu_bus.op = I_PWDATA[2:0];
  assign alu_bus.a = state_reg.op_a;
  assign alu_bus.b = state_reg.op_b;
  assign alu_bus.carry_in = state_reg.carry;
  assign alu_bus.wc = state_reg.wc;
  assign alu_bus.compare_mode_bit = state_reg.compare_mode_bit;

  logic setup;
  logic commit;
  logic hit;
  logic [31:0] rd_word;
  logic [2:0] kind;
  logic [1:0] tgt_page;
  logic [12:0] tgt_low;

  assign setup = I_PSEL & ~I_PENABLE;
  assign commit = I_PSEL & I_PENABLE & state_reg.pready;
  assign kind = I_PWDATA[CCP_KIND_LSB +: 3];
  assign tgt_page = I_PWDATA[CCP_PAGE_LSB +: 2];
  assign tgt_low = I_PWDATA[CCP_LOW_W-1:0];

  // Read mux and decode, evaluated in the setup cycle
  always_comb
  begin
    rd_word = 32'h0000_0000;
    hit = 1'b1;
    if (I_PADDR == CCP_CTRL_OFS)
    begin
      rd_word[CCP_CARRY_BIT] = state_reg.carry;
      rd_word[CCP_COM_BIT] = state_reg.compare_mode_bit;
      rd_word[CCP_WC_BIT] = state_reg.wc;
      rd_word[CCP_CC_LSB +: 2] = state_reg.cc;
    end
    else if (I_PADDR == CCP_OPER_OFS)
    begin
      rd_word[7:0] = state_reg.op_a;
      rd_word[CCP_OPB_LSB +: 8] = state_reg.op_b;
    end
    else if (I_PADDR == CCP_ALU_CMD_OFS)
      rd_word = 32'h0000_0000;
    else if (I_PADDR == CCP_RESULT_OFS)
      rd_word[7:0] = state_reg.result;
    else if (I_PADDR == CCP_ADDR_CMD_OFS)
      rd_word = 32'h0000_0000;
    else if (I_PADDR == CCP_ADDR_STAT_OFS)
    begin
      rd_word[CCP_LOW_W-1:0] = state_reg.low_addr;
      rd_word[CCP_PAGE_LSB +: 2] = state_reg.page_out;
      rd_word[CCP_LATCH_LSB +: 2] = state_reg.page;
      rd_word[CCP_BUSY_BIT] = (state_reg.st == CCP_ADR_HOLD);
    end
    else
      hit = 1'b0;
  end

  always_comb
  begin
    state_next = state_reg;
    // Registered ready: one access cycle per transfer, no wait states
    state_next.pready = setup;
    state_next.strobe = 1'b0;
    if (setup)
    begin
      state_next.prdata = rd_word;
      state_next.pslverr = ~hit;
    end

    // Temporary indirect page expires back to the latched page
    case (state_reg.st)
      CCP_ADR_IDLE:
        state_next.page_out = state_reg.page;
      CCP_ADR_HOLD:
      begin
        if (state_reg.hold == '0)
        begin
          state_next.page_out = state_reg.page;
          state_next.st = CCP_ADR_IDLE;
        end
        else
          state_next.hold = state_reg.hold - HOLD_W'(1);
      end
      default:
        state_next.st = CCP_ADR_IDLE;
    endcase

    if (commit && I_PWRITE && hit)
    begin
      if (I_PADDR == CCP_CTRL_OFS)
      begin
        state_next.carry = I_PWDATA[CCP_CARRY_BIT];
        state_next.compare_mode_bit = I_PWDATA[CCP_COM_BIT];
        state_next.wc = I_PWDATA[CCP_WC_BIT];
        state_next.cc = I_PWDATA[CCP_CC_LSB +: 2];
      end
      else if (I_PADDR == CCP_OPER_OFS)
      begin
        state_next.op_a = I_PWDATA[7:0];
        state_next.op_b = I_PWDATA[CCP_OPB_LSB +: 8];
      end
      else if (I_PADDR == CCP_ALU_CMD_OFS)
      begin
        // Unknown operation codes leave every flag alone
        if (alu_bus.valid_op)
        begin
          state_next.cc = alu_bus.cc;
          if (alu_bus.op != CCP_OP_CMP)
          begin
            state_next.result = alu_bus.result;
            state_next.carry = alu_bus.carry_out;
          end
        end
      end
      else if (I_PADDR == CCP_ADDR_CMD_OFS)
      begin
        state_next.low_addr = tgt_low;
        state_next.strobe = 1'b1;
        state_next.st = CCP_ADR_IDLE;
        case (kind)
          CCP_ACC_FETCH:
            state_next.page_out = state_reg.page;
          CCP_ACC_DIRECT:
            state_next.page_out = state_reg.page;
          CCP_ACC_INDIRECT:
          begin
            // Latch untouched; only the lines carry the operand page
            state_next.page_out = tgt_page;
            state_next.hold = HOLD_LOAD;
            state_next.st = CCP_ADR_HOLD;
          end
          CCP_ACC_BRANCH:
          begin
            state_next.page = tgt_page;
            state_next.page_out = tgt_page;
          end
          CCP_ACC_IRQ:
          begin
            state_next.page = CCP_PAGE_IRQ;
            state_next.page_out = CCP_PAGE_IRQ;
          end
          default:
          begin
            state_next.strobe = 1'b0;
            state_next.low_addr = state_reg.low_addr;
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      state_reg <= RESET_STATE;
    else if (I_CE)
      state_reg <= state_next;
  end

  assign O_PRDATA = state_reg.prdata;
  assign O_PREADY = state_reg.pready;
  assign O_PSLVERR = state_reg.pslverr;
  assign O_LOW_ADDRESS_LINES = state_reg.low_addr;
  assign O_PAGE_ADDRESS_LINE_LOW = state_reg.page_out[0];
  assign O_PAGE_ADDRESS_LINE_HIGH = state_reg.page_out[1];
  assign O_ADDR_STROBE = state_reg.strobe;
  assign O_CARRY = state_reg.carry;
  assign O_CONDITION_CODE = state_reg.cc;
endmodule

/* File: bench/ccp_core_assertions.sv */
`timescale 1ns/1ps
module ccp_core_assertions
  import ccp_pkg::*;
#(
  parameter int HOLD_CYCLES = 1
)
(
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  // APB
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  // Address and status
  input wire logic [12:0] O_LOW_ADDRESS_LINES,
  input wire logic O_PAGE_ADDRESS_LINE_LOW,
  input wire logic O_PAGE_ADDRESS_LINE_HIGH,
  input wire logic O_ADDR_STROBE,
  input wire logic O_CARRY,
  input wire logic [1:0] O_CONDITION_CODE
);
  logic [15:0] op_q;
  logic wc_q;
  logic com_q;
  logic [1:0] lat_q;
  wire wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY & I_CE;
  wire [2:0] k = I_PWDATA[18:16];
  wire [2:0] op = I_PWDATA[2:0];
  wire acmd = wr && I_PADDR == CCP_ADDR_CMD_OFS;
  wire alu = wr && I_PADDR == CCP_ALU_CMD_OFS;
  wire [1:0] pg = {O_PAGE_ADDRESS_LINE_HIGH, O_PAGE_ADDRESS_LINE_LOW};
  wire [7:0] a = op_q[7:0];
  wire [7:0] b = op_q[15:8];
  wire [8:0] s9 = a + b + (wc_q & O_CARRY);
  wire [8:0] d9 = a - b - (wc_q & ~O_CARRY);
  wire gt = com_q ? a > b : $signed(a) > $signed(b);
  wire [1:0] cc = a == b ? CCP_CC_EQ : gt ? CCP_CC_GT : CCP_CC_LT;

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      op_q <= '0;
      wc_q <= 1'b0;
      com_q <= 1'b0;
      lat_q <= CCP_PAGE_RESET;
    end
    else
    begin
      if (wr && I_PADDR == CCP_OPER_OFS)
        op_q <= I_PWDATA[15:0];
      if (wr && I_PADDR == CCP_CTRL_OFS)
        {wc_q, com_q} <= {I_PWDATA[CCP_WC_BIT], I_PWDATA[CCP_COM_BIT]};
      if (acmd && k == CCP_ACC_BRANCH)
        lat_q <= I_PWDATA[14:13];
      if (acmd && k == CCP_ACC_IRQ)
        lat_q <= CCP_PAGE_IRQ;
    end
  end

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  AST_STROBE: assert property (acmd && k < 3'h5 |=> O_ADDR_STROBE &&
    O_LOW_ADDRESS_LINES == $past(I_PWDATA[12:0])) else $error("address not presented");
  AST_BRANCH: assert property (acmd && k == CCP_ACC_BRANCH |=>
    pg == $past(I_PWDATA[14:13])) else $error("branch page not loaded");
  AST_IRQ: assert property (acmd && k == CCP_ACC_IRQ |=>
    pg == CCP_PAGE_IRQ) else $error("interrupt page not zero");
  AST_IND: assert property (acmd && k == CCP_ACC_INDIRECT |=>
    pg == $past(I_PWDATA[14:13])) else $error("indirect page not shown");
  // Valid for a one-cycle indirect hold only
  AST_LATCH: assert property (!O_ADDR_STROBE |->
    pg == lat_q) else $error("page lines differ from latch");
  AST_RST: assert property ($rose(I_ARST_N) |->
    pg == CCP_PAGE_RESET) else $error("page not cleared by reset");
  AST_ADD: assert property (alu && op == CCP_OP_ADD |=>
    O_CARRY == $past(s9[8])) else $error("add carry wrong");
  AST_SUB: assert property (alu && op == CCP_OP_SUB |=>
    O_CARRY == !$past(d9[8])) else $error("subtract borrow wrong");
  AST_CMP: assert property (alu && op == CCP_OP_CMP |=>
    O_CONDITION_CODE == $past(cc) && $stable(O_CARRY)) else $error("compare code wrong");

  cover property (acmd && k == CCP_ACC_BRANCH);
  cover property (acmd && k == CCP_ACC_INDIRECT);
  cover property (alu && op == CCP_OP_CMP);
endmodule

bind ccp_core ccp_core_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) ccp_core_assertions_inst (.*);

/* File: bench/ccp_mem_model.sv */
`timescale 1ns/1ps
module ccp_mem_model
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Address lines
  input wire logic [12:0] i_low,
  input wire logic i_pg_lo,
  input wire logic i_pg_hi,
  input wire logic i_stb,
  // Decoded byte address
  output logic [14:0] o_addr
);
  // Latches the full address only on a strobe
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_addr <= '0;
    else if (i_stb)
      o_addr <= {i_pg_hi, i_pg_lo, i_low};
  end
endmodule

/* File: bench/test_carry_compare_and_page_addressing.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_carry_compare_and_page_addressing;
  import ccp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] low;
  logic pl;
  logic ph;
  logic stb;
  logic carry;
  logic [1:0] cc;
  logic [14:0] maddr;
  logic [31:0] rd;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // ctl, {B,A}, op, result, carry, cc
  logic [43:0] t [11] = '{44'h0901FF00111, 44'h01010100201, 44'h08030510111,
    44'h09050510010, 44'h0005031FE02, 44'h0201802FE01, 44'h0001802FE02,
    44'h0042422FE00, 44'h09008030111, 44'h08000140010, 44'h01008130311};
  // kind, address, expected page
  logic [23:0] at [5] = '{24'h360053, 24'h001233, 24'h220101, 24'h11FFF3, 24'h440400};

  always #50 clk = ~clk;

  ccp_core #(.HOLD_CYCLES(1)) ccp_core_inst (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_LOW_ADDRESS_LINES(low),
    .O_PAGE_ADDRESS_LINE_LOW(pl), .O_PAGE_ADDRESS_LINE_HIGH(ph), .O_ADDR_STROBE(stb),
    .O_CARRY(carry), .O_CONDITION_CODE(cc));
  ccp_mem_model ccp_mem_model_inst (.i_clk(clk), .i_arst_n(arst_n), .i_low(low),
    .i_pg_lo(pl), .i_pg_hi(ph), .i_stb(stb), .o_addr(maddr));

  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Starts on an edge so back-to-back calls never drive psel twice at once
  // Ready and read data are taken at the rising edge that completes the access
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    {psel, pen} <= 2'b00;
  endtask

  task automatic alu(input logic [7:0] ctl, input logic [15:0] ab, input logic [2:0] op);
    xfer(1'b1, CCP_CTRL_OFS, {24'h0, ctl});
    xfer(1'b1, CCP_OPER_OFS, {16'h0, ab});
    xfer(1'b1, CCP_ALU_CMD_OFS, {29'h0, op});
    @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    `CHK("page", 2'h0, {ph, pl})
    foreach (t[i])
    begin
      alu(t[i][43:36], t[i][35:20], t[i][18:16]);
      `CHK("carry", t[i][4], carry)
      `CHK("cc", t[i][1:0], cc)
      xfer(1'b0, CCP_RESULT_OFS, 32'h0);
      `CHK("result", {24'h0, t[i][15:8]}, rd)
    end
    foreach (at[i])
    begin
      xfer(1'b1, CCP_ADDR_CMD_OFS, {13'h0, at[i][22:20], 1'b0, at[i][18:4]});
      @(negedge clk);
      `CHK("page", at[i][1:0], {ph, pl})
      `CHK("low", at[i][16:4], low)
      @(negedge clk);
      `CHK("mem", {at[i][1:0], at[i][16:4]}, maddr)
    end
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("err", 1'b1, pslverr)
    `CHK("rd", 32'h0, rd)
    xfer(1'b0, CCP_ADDR_STAT_OFS, 32'h0);
    `CHK("stat", 32'h40, rd)
    xfer(1'b1, CCP_ADDR_CMD_OFS, {13'h0, CCP_ACC_BRANCH, 16'h4000});
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    `CHK("page", 2'h0, {ph, pl})
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    results();
  end
endmodule
